//--- isrp_pkg.sv
// constants and types shared by the serial register port
// assumes a 200 MHz system clock and a bus master on the two-wire pins
package isrp_pkg;

   localparam logic [6:0] SLAVE_ADDR = 7'h6B;
   localparam logic [7:0] FIRST_REG = 8'h00;
   localparam logic [7:0] LAST_REG = 8'h0B;
   localparam logic [7:0] FAULT_REG = 8'h09;
   localparam logic [7:0] UNMAPPED_BYTE = 8'hFF;
   localparam logic [7:0] FAULT_NONE = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam int NUM_REGS = 12;
   localparam int REG_WIDTH = 8;

   // bit counter values: 0..7 data bits, 8 is the acknowledge slot
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST_DATA = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_STEP = 4'h1;

   // power-on values, index 0 in the low byte; unknown contents start at zero
   localparam logic [NUM_REGS-1:0][REG_WIDTH-1:0] REG_RESET = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'hA2, 8'h1A, 8'h17
   };

   localparam int SYS_CLK_MHZ = 200;
   localparam int FAULT_PULSE_US = 256;
   localparam int FAULT_PULSE_CYCLES = FAULT_PULSE_US * SYS_CLK_MHZ;

   localparam logic [2:0] SYNC_RESET_LOW = 3'h0;
   localparam logic [2:0] SYNC_RESET_HIGH = 3'h7;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR,
      PH_PTR,
      PH_WDATA,
      PH_RDATA
   } isrp_phase_type;

endpackage

//--- isrp_link_sampler.sv
// bus-clock side of the serial port: samples the data line on each rising clock edge
// assumes the clock port is the bus clock pin and stands still between frames
`timescale 1ns/1ps

module isrp_link_sampler
   import isrp_pkg::*;
(
   input wire logic sclClk,
   input wire logic rst_n,
   input wire logic sdaIn,
   output logic bitTog,
   output logic bitVal
);

   typedef struct packed {
      logic tog;
      logic val;
   } isrp_link_state_type;

   isrp_link_state_type state_reg;
   isrp_link_state_type state_next;

   ////////////////////////////////////////////////////////////////////////////
   // one toggle per clock pulse carries the bit into the system domain
   always_comb begin
      state_next = state_reg;
      state_next.tog = ~state_reg.tog;
      state_next.val = sdaIn;
   end

   always_ff @(posedge sclClk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bitTog = state_reg.tog;
   assign bitVal = state_reg.val;

endmodule

//--- isrp_port.sv
// two-wire slave register port with a twelve byte register bank
// assumes open-drain pads outside, the bus clock pin also wired to sclClk,
// and fault event inputs from logic on sys_clk
`timescale 1ns/1ps

module isrp_port
   import isrp_pkg::*;
#(
   parameter int PULSE_CYCLES = FAULT_PULSE_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sclClk,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOe,
   output logic sclOe,
   input wire logic [REG_WIDTH-1:0] faultIn,
   output logic faultIntN,
   output logic [NUM_REGS*REG_WIDTH-1:0] regBank
);

   localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PULSE_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_STEP = CNT_W'(1);

   typedef logic [NUM_REGS-1:0][REG_WIDTH-1:0] isrp_bank_type;

   typedef struct packed {
      logic [2:0] sdaSync;
      logic [2:0] sclSync;
      logic [2:0] togSync;
      logic [1:0] bitSync;
      logic sdaF;
      logic sclF;
      logic togF;
      isrp_phase_type phase;
      isrp_phase_type pendPhase;
      logic [3:0] bitCnt;
      logic [7:0] rxShift;
      logic [7:0] txShift;
      logic [7:0] ptr;
      logic ackReg;
      logic sdaOe;
      logic sclOe;
      isrp_bank_type bank;
      logic [CNT_W-1:0] pulseCnt;
      logic faultIntN;
   } isrp_port_state_type;

   isrp_port_state_type state_reg;
   isrp_port_state_type state_next;

   logic linkTog;
   logic linkBit;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [7:0] nextPtr(input logic [7:0] p);
      logic [7:0] s;
      s = p + PTR_STEP;
      if (s == FAULT_REG) begin
         s = s + PTR_STEP;
      end
      return s;
   endfunction

   function automatic logic [7:0] readByte(input isrp_bank_type b, input logic [7:0] p);
      logic [7:0] v;
      v = UNMAPPED_BYTE;
      if (p <= LAST_REG) begin
         v = b[p[3:0]];
      end
      return v;
   endfunction

   function automatic logic regWritable(input logic [7:0] p);
      // the fault register is only ever filled by hardware
      return (p <= LAST_REG) && (p != FAULT_REG);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus clock domain

   isrp_link_sampler u_link (
      .sclClk(sclClk),
      .rst_n(rst_n),
      .sdaIn(sdaIn),
      .bitTog(linkTog),
      .bitVal(linkBit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // system clock domain

   always_comb begin
      logic startEv;
      logic stopEv;
      logic sclFall;
      logic bitEv;
      logic bitV;
      logic clearFault;
      logic [7:0] rxByte;
      startEv = 1'b0;
      stopEv = 1'b0;
      sclFall = 1'b0;
      bitEv = 1'b0;
      bitV = 1'b0;
      clearFault = 1'b0;
      rxByte = 8'h00;
      state_next = state_reg;

      // pins and the bit toggle pass three flops; a change counts once two agree
      state_next.sdaSync = {state_reg.sdaSync[1:0], sdaIn};
      state_next.sclSync = {state_reg.sclSync[1:0], sclIn};
      state_next.togSync = {state_reg.togSync[1:0], linkTog};
      state_next.bitSync = {state_reg.bitSync[0], linkBit};
      if (state_reg.sdaSync[1] == state_reg.sdaSync[2]) begin
         state_next.sdaF = state_reg.sdaSync[2];
      end
      if (state_reg.sclSync[1] == state_reg.sclSync[2]) begin
         state_next.sclF = state_reg.sclSync[2];
      end
      if (state_reg.togSync[1] == state_reg.togSync[2]) begin
         state_next.togF = state_reg.togSync[2];
      end

      // equal depth on both paths keeps bits ordered against start and stop
      startEv = state_reg.sclF && state_next.sclF && state_reg.sdaF && !state_next.sdaF;
      stopEv = state_reg.sclF && state_next.sclF && !state_reg.sdaF && state_next.sdaF;
      sclFall = state_reg.sclF && !state_next.sclF;
      bitEv = state_next.togF != state_reg.togF;
      bitV = state_reg.bitSync[1];

      ////////////////////////////////////////////////////////////////////////
      // byte sequencing

      if (startEv) begin
         // a cut-short byte is simply dropped here
         state_next.phase = PH_ADDR;
         state_next.bitCnt = BIT_FIRST;
         state_next.ackReg = 1'b0;
         state_next.sdaOe = 1'b0;
      end else if (stopEv) begin
         state_next.phase = PH_IDLE;
         state_next.bitCnt = BIT_FIRST;
         state_next.ackReg = 1'b0;
         state_next.sdaOe = 1'b0;
      end else if (bitEv && (state_reg.phase != PH_IDLE)) begin
         if (state_reg.bitCnt != BIT_ACK) begin
            state_next.rxShift = {state_reg.rxShift[6:0], bitV};
            state_next.bitCnt = state_reg.bitCnt + BIT_STEP;
            rxByte = state_next.rxShift;
            if (state_reg.bitCnt == BIT_LAST_DATA) begin
               case (state_reg.phase)
                  PH_ADDR: begin
                     if (rxByte[7:1] == SLAVE_ADDR) begin
                        state_next.ackReg = 1'b1;
                        if (rxByte[0]) begin
                           state_next.pendPhase = PH_RDATA;
                           state_next.txShift = readByte(state_reg.bank, state_reg.ptr);
                        end else begin
                           state_next.pendPhase = PH_PTR;
                        end
                     end else begin
                        state_next.ackReg = 1'b0;
                        state_next.pendPhase = PH_IDLE;
                     end
                  end
                  PH_PTR: begin
                     if (rxByte <= LAST_REG) begin
                        state_next.ackReg = 1'b1;
                        state_next.pendPhase = PH_WDATA;
                     end else begin
                        state_next.ackReg = 1'b0;
                        state_next.pendPhase = PH_IDLE;
                     end
                  end
                  PH_WDATA: begin
                     state_next.ackReg = 1'b1;
                     state_next.pendPhase = PH_WDATA;
                  end
                  PH_RDATA: begin
                     // the master answers this byte, so the line stays released
                     state_next.ackReg = 1'b0;
                     state_next.pendPhase = PH_RDATA;
                  end
                  default: begin
                     state_next.ackReg = 1'b0;
                     state_next.pendPhase = PH_IDLE;
                  end
               endcase
            end
         end else begin
            // acknowledge slot has been clocked
            state_next.bitCnt = BIT_FIRST;
            state_next.phase = state_reg.pendPhase;
            case (state_reg.phase)
               PH_PTR: begin
                  if (state_reg.ackReg) begin
                     state_next.ptr = state_reg.rxShift;
                  end
               end
               PH_WDATA: begin
                  if (regWritable(state_reg.ptr)) begin
                     state_next.bank[state_reg.ptr[3:0]] = state_reg.rxShift;
                  end
                  state_next.ptr = nextPtr(state_reg.ptr);
               end
               PH_RDATA: begin
                  if (state_reg.ptr == FAULT_REG) begin
                     clearFault = 1'b1;
                  end
                  if (!bitV) begin
                     state_next.ptr = nextPtr(state_reg.ptr);
                     state_next.txShift = readByte(state_reg.bank, nextPtr(state_reg.ptr));
                  end else begin
                     state_next.phase = PH_IDLE;
                  end
               end
               default: begin
                  state_next.ptr = state_reg.ptr;
               end
            endcase
            state_next.ackReg = 1'b0;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // line drive, changed only just after the clock falls

      if (sclFall) begin
         if ((state_next.phase == PH_RDATA) && (state_next.bitCnt != BIT_ACK)) begin
            state_next.sdaOe = ~state_next.txShift[7];
            state_next.txShift = {state_next.txShift[6:0], 1'b1};
         end else begin
            state_next.sdaOe = (state_next.bitCnt == BIT_ACK) && state_next.ackReg;
         end
      end

      // reply bytes are ready before each falling edge, so no hold is needed
      state_next.sclOe = 1'b0;

      ////////////////////////////////////////////////////////////////////////
      // fault latch and its single notification pulse

      if (!state_reg.faultIntN) begin
         if (state_reg.pulseCnt == CNT_ZERO) begin
            state_next.faultIntN = 1'b1;
         end else begin
            state_next.pulseCnt = state_reg.pulseCnt - CNT_STEP;
         end
      end else if ((faultIn != FAULT_NONE) && (state_reg.bank[FAULT_REG[3:0]] == FAULT_NONE)) begin
         // earlier faults must be read away before a new pulse
         state_next.faultIntN = 1'b0;
         state_next.pulseCnt = CNT_LOAD;
      end

      // a fault arriving with the clearing read survives it
      if (clearFault) begin
         state_next.bank[FAULT_REG[3:0]] = faultIn;
      end else begin
         state_next.bank[FAULT_REG[3:0]] = state_reg.bank[FAULT_REG[3:0]] | faultIn;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.sdaSync <= SYNC_RESET_HIGH;
         state_reg.sclSync <= SYNC_RESET_HIGH;
         state_reg.togSync <= SYNC_RESET_LOW;
         state_reg.bitSync <= 2'h0;
         state_reg.sdaF <= 1'b1;
         state_reg.sclF <= 1'b1;
         state_reg.togF <= 1'b0;
         state_reg.phase <= PH_IDLE;
         state_reg.pendPhase <= PH_IDLE;
         state_reg.bitCnt <= BIT_FIRST;
         state_reg.rxShift <= 8'h00;
         state_reg.txShift <= 8'hFF;
         state_reg.ptr <= FIRST_REG;
         state_reg.ackReg <= 1'b0;
         state_reg.sdaOe <= 1'b0;
         state_reg.sclOe <= 1'b0;
         state_reg.bank <= REG_RESET;
         state_reg.pulseCnt <= CNT_ZERO;
         state_reg.faultIntN <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register

   assign sdaOe = state_reg.sdaOe;
   assign sclOe = state_reg.sclOe;
   assign faultIntN = state_reg.faultIntN;
   assign regBank = state_reg.bank;

endmodule

//--- isrp_port_sva.sv
// checker for the serial register port, top-level ports only
// assumes one sys_clk domain and open-drain bus lines outside
`timescale 1ns/1ps
module isrp_port_sva
   import isrp_pkg::*;
#(
   parameter int PULSE_CYCLES = FAULT_PULSE_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sclClk,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOe,
   input wire logic sclOe,
   input wire logic [REG_WIDTH-1:0] faultIn,
   input wire logic faultIntN,
   input wire logic [NUM_REGS*REG_WIDTH-1:0] regBank
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [31:0] lowCnt_reg;
   logic [REG_WIDTH-1:0] faultReg;
   assign faultReg = regBank[FAULT_REG*REG_WIDTH +: REG_WIDTH];
////////////////////////////////////////////////////////////
   // pulse is far too long for a repetition, so count it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt_reg <= 32'h0;
      end else begin
         lowCnt_reg <= faultIntN ? 32'h0 : lowCnt_reg + 32'h1;
      end
   end
////////////////////////////////////////////////////////////
   a_pulse_width: assert property ($rose(faultIntN) |-> lowCnt_reg == PULSE_CYCLES)
      else $error("notification pulse has wrong length");
   a_pulse_trigger: assert property ((faultIn != FAULT_NONE && faultIntN && faultReg == FAULT_NONE) |=> !faultIntN)
      else $error("fault event raised no pulse");
   a_pulse_cause: assert property ($fell(faultIntN) |-> $past(faultIn) != FAULT_NONE)
      else $error("pulse without fault event");
   a_pulse_blocked: assert property ((faultReg != FAULT_NONE && faultIntN) |=> faultIntN)
      else $error("second pulse while faults still latched");
   a_fault_latch: assert property (faultIn != FAULT_NONE |=> (faultReg & $past(faultIn)) == $past(faultIn))
      else $error("fault bit not latched");
   a_no_stretch: assert property (!sclOe)
      else $error("clock line pulled");
   a_open_drain: assert property (sdaOe |-> !sdaIn)
      else $error("data line high while pulled");
   a_sda_rise_low: assert property ($rose(sdaOe) |-> !sclIn)
      else $error("data pulled while clock high");
   a_sda_fall_low: assert property ($fell(sdaOe) |-> !sclIn)
      else $error("data released while clock high");
   a_sda_steady_high: assert property ((sclIn && $past(sclIn)) |-> $stable(sdaOe))
      else $error("data drive changed while clock high");
endmodule

//--- isrp_bus_master.sv
// two-wire bus master model, lines only pulled low or released
// assumes pull-ups on both lines; clock stands still between frames
`timescale 1ns/1ps
module isrp_bus_master (
   input wire logic sda,
   input wire logic scl,
   output logic pullSda,
   output logic pullScl
);
   // 48 ns bit time is beyond the bus rating, traded for run time
   initial begin
      pullSda = 1'b0;
      pullScl = 1'b0;
   end
////////////////////////////////////////////////////////////
   task automatic bitOut(input logic b);
      #5 pullSda = !b;
      #23 pullScl = 1'b0;
      wait (scl === 1'b1);
      #20 pullScl = 1'b1;
   endtask
   task automatic bitIn(output logic b);
      #5 pullSda = 1'b0;
      #23 pullScl = 1'b0;
      wait (scl === 1'b1);
      #10 b = sda;
      #10 pullScl = 1'b1;
   endtask
   task automatic start();
      #5 pullSda = 1'b0;
      #23 pullScl = 1'b0;
      wait (scl === 1'b1);
      #20 pullSda = 1'b1;
      #20 pullScl = 1'b1;
   endtask
   task automatic stop();
      #5 pullSda = 1'b1;
      #23 pullScl = 1'b0;
      wait (scl === 1'b1);
      #20 pullSda = 1'b0;
      #40;
   endtask
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bitOut(d[i]);
      end
      bitIn(a);
      ack = !a;
   endtask
   task automatic recvByte(output logic [7:0] d, input logic ack);
      for (int i = 7; i >= 0; i--) begin
         bitIn(d[i]);
      end
      bitOut(!ack);
   endtask
endmodule

//--- testbench.sv
// self-checking bench for the serial register port
// assumes the master model drives the wired bus lines
`timescale 1ns/1ps
module testbench;
   import isrp_pkg::*;
   localparam int PULSE = 20;
   logic sys_clk, rst_n, sdaOe, sclOe, faultIntN, pullSda, pullScl, a1, a2, a3;
   logic [7:0] faultIn, d;
   logic [NUM_REGS*REG_WIDTH-1:0] regBank;
   wire sda;
   wire scl;
   int fails = 0;
   int samples_checked = 0;
   int cyc = 0;
   assign sda = !(pullSda || sdaOe);
   assign scl = !(pullScl || sclOe);
   isrp_port #(.PULSE_CYCLES(PULSE)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .sclClk(scl), .sclIn(scl),
      .sdaIn(sda), .sdaOe(sdaOe), .sclOe(sclOe), .faultIn(faultIn), .faultIntN(faultIntN), .regBank(regBank));
   isrp_bus_master mst (.sda(sda), .scl(scl), .pullSda(pullSda), .pullScl(pullScl));
////////////////////////////////////////////////////////////
   task automatic final_report();
      if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] rb(input int i);
      return regBank[i*8 +: 8];
   endfunction
   task automatic addrPtr(input logic [7:0] p);
      mst.start();
      mst.sendByte({SLAVE_ADDR, 1'b0}, a1);
      mst.sendByte(p, a2);
   endtask
   task automatic readOne(input logic [7:0] p, output logic [7:0] q);
      addrPtr(p);
      mst.start();
      mst.sendByte({SLAVE_ADDR, 1'b1}, a3);
      mst.recvByte(q, 1'b0);
      mst.stop();
   endtask
////////////////////////////////////////////////////////////
   task automatic tReset();
      for (int i = 0; i < NUM_REGS; i++) begin
         check(rb(i), REG_RESET[i]);
      end
   endtask
   task automatic tBadAddr();
      mst.start();
      mst.sendByte({SLAVE_ADDR ^ 7'h01, 1'b0}, a1);
      mst.stop();
      check({7'h00, a1}, 8'h00);
   endtask
   task automatic tWrite();
      addrPtr(8'h08);
      mst.sendByte(8'h11, a3);
      mst.sendByte(8'h22, a3);
      mst.sendByte(8'h33, a3);
      mst.stop();
      check({6'h00, a1, a2}, 8'h03);
      check(rb(8), 8'h11);
      check(rb(9), 8'h00);
      check(rb(10), 8'h22);
      check(rb(11), 8'h33);
   endtask
   task automatic tBadPtr();
      addrPtr(8'h0C);
      mst.stop();
      check({7'h00, a2}, 8'h00);
   endtask
   task automatic tRead();
      addrPtr(8'h08);
      mst.start();
      mst.sendByte({SLAVE_ADDR, 1'b1}, a3);
      check({7'h00, a3}, 8'h01);
      mst.recvByte(d, 1'b1);
      check(d, 8'h11);
      mst.recvByte(d, 1'b1);
      check(d, 8'h22);
      mst.recvByte(d, 1'b1);
      check(d, 8'h33);
      mst.recvByte(d, 1'b0);
      check(d, UNMAPPED_BYTE);
      mst.stop();
   endtask
   task automatic tCut();
      addrPtr(8'h03);
      repeat (4) mst.bitOut(1'b1);
      mst.stop();
      check(rb(3), 8'h00);
      addrPtr(8'h03);
      mst.sendByte(8'hA5, a3);
      mst.stop();
      check(rb(3), 8'hA5);
   endtask
   task automatic tMidReset();
      addrPtr(8'h00);
      mst.sendByte(8'h5A, a3);
      mst.stop();
      check(rb(0), 8'h5A);
      @(negedge sys_clk) rst_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      check(rb(0), REG_RESET[0]);
      check({7'h00, faultIntN}, 8'h01);
      // no pointer write: the read starts at the pointer's reset value
      mst.start();
      mst.sendByte({SLAVE_ADDR, 1'b1}, a3);
      mst.recvByte(d, 1'b0);
      mst.stop();
      check({7'h00, a3}, 8'h01);
      check(d, REG_RESET[0]);
   endtask
   task automatic tFault();
      int n;
      n = 0;
      @(negedge sys_clk) faultIn = 8'h04;
      @(negedge sys_clk) faultIn = 8'h00;
      while (faultIntN !== 1'b0 && n < 10) begin
         @(negedge sys_clk);
         n++;
      end
      n = 0;
      while (faultIntN === 1'b0 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      check(n[7:0], 8'(PULSE));
      @(negedge sys_clk) faultIn = 8'h01;
      @(negedge sys_clk) faultIn = 8'h00;
      repeat (30) @(negedge sys_clk);
      check({7'h00, faultIntN}, 8'h01);
      readOne(FAULT_REG, d);
      check(d, 8'h05);
      readOne(FAULT_REG, d);
      check(d, 8'h00);
   endtask
////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      rst_n = 1'b0;
      faultIn = 8'h00;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk) rst_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      tReset();
      tBadAddr();
      tWrite();
      tBadPtr();
      tRead();
      tCut();
      tMidReset();
      tFault();
      final_report();
   end
endmodule
bind isrp_port isrp_port_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .sclClk(sclClk),
   .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe), .sclOe(sclOe), .faultIn(faultIn), .faultIntN(faultIntN),
   .regBank(regBank));
